// file: rtl/mpi_core.sv
// mii pin interface: nibble tx/rx, serial mode, compress flag, avalon regs
//
// Functional notes
// RQ1: transmit error driven in step with tx clock
// RQ2: serial mode: compress flag after destination address
// RQ3: control selects match or no-match assertion
// RQ4: control bit selects compress output polarity
// RQ5: phy raises carrier sense when medium busy
// RQ6: phy supplies free-running 25 or 2.5 MHz rx clock; the phy model here runs it at 3.125 MHz (320 ns period)
// RQ7: phy drives rx on fall, mac samples rise
// RQ8: first rx nibble forms the byte's low half
// RQ9: phy holds data valid over valid nibbles
// RQ10: nibbles before sfd are taken as preamble
// RQ11: phy flags rx error only with data valid
// RQ12: serial mode: data valid is link, stored
// RQ13: serial mode: rx bit 0 is serial data
// RQ14: tx nibble and enable change on tx rise
// RQ15: tx byte low nibble first, bit 0 first
// RQ16: tx enable spans preamble through last byte
// RQ17: serial mode: tx bit 1 loopback, bit 0 data
// RQ18: carrier and collision pass two-stage synchroniser
// RQ19: second controller is an identical separate instance
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module mpi_core (
    input  wire logic        clk,
    input  wire logic        nrst,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    // phy pins
    input  wire logic        tx_clk,
    output logic [3:0]       txd,
    output logic             tx_en,
    output logic             tx_err,
    input  wire logic        rx_clk,
    input  wire logic [3:0]  rxd,
    input  wire logic        rx_dv,
    input  wire logic        rx_err,
    input  wire logic        crs,
    input  wire logic        col
);
    typedef enum logic [1:0] {
        mpi_tx_idle_type = 2'b00,
        mpi_tx_pre_type  = 2'b01,
        mpi_tx_lo_type   = 2'b10,
        mpi_tx_hi_type   = 2'b11
    } mpi_tx_state_type;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic txc_lvl, txc_rise, rxc_lvl, rxc_rise;
    logic crs_lvl, col_lvl, col_rise, dv_lvl, err_lvl, link_chg_r, link_chg_f;
    logic [3:0] rxd_meta, rxd_s;

    mpi_edge_sync u_txc (.clk(clk), .nrst(nrst), .async_in(tx_clk), // RQ14
        .level(txc_lvl), .rise(txc_rise), .fall());
    mpi_edge_sync u_rxc (.clk(clk), .nrst(nrst), .async_in(rx_clk),
        .level(rxc_lvl), .rise(rxc_rise), .fall());
    mpi_edge_sync u_crs (.clk(clk), .nrst(nrst), .async_in(crs),
        .level(crs_lvl), .rise(), .fall()); // RQ18
    mpi_edge_sync u_col (.clk(clk), .nrst(nrst), .async_in(col),
        .level(col_lvl), .rise(col_rise), .fall()); // RQ18
    mpi_edge_sync u_dv (.clk(clk), .nrst(nrst), .async_in(rx_dv),
        .level(dv_lvl), .rise(link_chg_r), .fall(link_chg_f));
    mpi_edge_sync u_err (.clk(clk), .nrst(nrst), .async_in(rx_err),
        .level(err_lvl), .rise(), .fall());

    // rx data bits ride two stages, matching the other rx pins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rxd_meta <= 4'h0;
            rxd_s    <= 4'h0;
        end else begin
            rxd_meta <= rxd;
            rxd_s    <= rxd_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] ctrl;
    logic [31:0] filter;
    localparam int ev_w = mpi_pkg::ev_width;
    logic [ev_w-1:0] irq_st, irq_mask, ev;
    logic [7:0] tx_hold;
    logic       tx_hold_last, tx_hold_full;
    logic [7:0] rx_byte;
    logic       rx_byte_err, rx_byte_new;
    logic       link_st;
    logic       wr_hit, rd_hit, tx_busy;
    logic       serial_mode, comp_act;

    assign serial_mode = ctrl[mpi_pkg::ctrl_serial_bit];
    // one wait state, so read data stand when waitrequest is seen low
    assign wr_hit = avs_write & ~avs_waitrequest;
    assign rd_hit = avs_read & avs_waitrequest;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) avs_waitrequest <= 1'b1;
        else avs_waitrequest <= ~(avs_read | avs_write) | ~avs_waitrequest;
    end

    // control and address filter registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl   <= mpi_pkg::ctrl_reset;
            filter <= mpi_pkg::filter_reset;
        end else if (wr_hit) begin
            if (avs_address == mpi_pkg::ctrl_addr)   ctrl   <= avs_writedata;
            if (avs_address == mpi_pkg::filter_addr) filter <= avs_writedata;
        end
    end

    // serial mode: data-valid pin is the link state, kept readable
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) link_st <= 1'b0;
        else if (serial_mode) link_st <= dv_lvl; // RQ12
    end

    // event flags: set beats a write-one clear in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) irq_st <= '0;
        else if (wr_hit && avs_address == mpi_pkg::irq_addr)
            irq_st <= (irq_st & ~avs_writedata[ev_w-1:0]) | ev;
        else
            irq_st <= irq_st | ev;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) irq_mask <= '0;
        else if (wr_hit && avs_address == mpi_pkg::mask_addr)
            irq_mask <= avs_writedata[ev_w-1:0];
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) irq <= 1'b0;
        else       irq <= |(irq_st & irq_mask);
    end

    // read mux, unmapped offsets read zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) avs_readdata <= 32'h0000_0000;
        else if (rd_hit) begin
            unique case (avs_address)
                mpi_pkg::ctrl_addr:   avs_readdata <= ctrl;
                mpi_pkg::filter_addr: avs_readdata <= filter;
                mpi_pkg::irq_addr:    avs_readdata <= 32'(irq_st);
                mpi_pkg::mask_addr:   avs_readdata <= 32'(irq_mask);
                mpi_pkg::rxdata_addr: avs_readdata <=
                    {22'h0, rx_byte_err, rx_byte_new, rx_byte};
                mpi_pkg::status_addr: avs_readdata <= {27'h0,
                    ~tx_hold_full, tx_busy, col_lvl, crs_lvl, link_st};
                default:              avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit: one-byte holding register feeds the tx nibble machine
    mpi_tx_state_type tx_state;
    logic [4:0] pre_cnt;
    logic [7:0] tx_byte;
    logic       tx_last, tx_take, tx_done;
    logic [2:0] ser_bit;

    assign tx_busy = (tx_state != mpi_tx_idle_type);
    // software must not write tx data while the room bit is clear
    assign tx_take = txc_rise && tx_hold_full &&
        (tx_state == mpi_tx_idle_type ||
         (tx_state == mpi_tx_hi_type && !tx_last) ||
         (tx_state == mpi_tx_pre_type && pre_cnt == mpi_pkg::pre_nibbles));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_hold      <= 8'h00;
            tx_hold_last <= 1'b0;
            tx_hold_full <= 1'b0;
        end else if (wr_hit && avs_address == mpi_pkg::txdata_addr) begin
            tx_hold      <= avs_writedata[7:0];
            tx_hold_last <= avs_writedata[mpi_pkg::txd_last_bit];
            tx_hold_full <= 1'b1;
        end else if (tx_take && tx_state != mpi_tx_idle_type) begin
            tx_hold_full <= 1'b0;
        end
    end

    // the first byte arms the preamble; later ones are consumed in order
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_state <= mpi_tx_idle_type;
            pre_cnt  <= 5'h00;
            tx_byte  <= 8'h00;
            tx_last  <= 1'b0;
            tx_done  <= 1'b0;
            ser_bit  <= 3'h0;
        end else begin
            tx_done <= 1'b0;
            if (txc_rise) begin // RQ14
                unique case (tx_state)
                    mpi_tx_idle_type: if (tx_hold_full) begin
                        tx_state <= mpi_tx_pre_type;
                        pre_cnt  <= 5'h00;
                    end
                    mpi_tx_pre_type: begin
                        if (pre_cnt == mpi_pkg::pre_nibbles) begin
                            tx_byte  <= tx_hold;
                            tx_last  <= tx_hold_last;
                            tx_state <= mpi_tx_lo_type;
                            ser_bit  <= 3'h0;
                        end else begin
                            pre_cnt <= pre_cnt + 5'h01;
                        end
                    end
                    mpi_tx_lo_type: begin
                        // serial mode walks eight bits before advancing
                        if (!serial_mode || ser_bit == 3'h7)
                            tx_state <= mpi_tx_hi_type;
                        else
                            ser_bit <= ser_bit + 3'h1;
                    end
                    mpi_tx_hi_type: begin
                        if (tx_last || !tx_hold_full) begin
                            tx_state <= mpi_tx_idle_type; // RQ16
                            tx_done  <= 1'b1;
                        end else begin
                            tx_byte  <= tx_hold;
                            tx_last  <= tx_hold_last;
                            tx_state <= mpi_tx_lo_type;
                            ser_bit  <= 3'h0;
                        end
                    end
                endcase
            end
        end
    end

    // pin drivers: preamble 5s then d, bytes low nibble first
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txd    <= 4'h0;
            tx_en  <= 1'b0;
            tx_err <= 1'b0;
        end else if (txc_rise) begin
            tx_err <= ctrl[mpi_pkg::ctrl_txerr_bit] & tx_busy; // RQ1
            if (serial_mode)
                tx_err <= comp_act ~^ ctrl[mpi_pkg::ctrl_pol_bit]; // RQ2 RQ4
            tx_en <= (tx_state != mpi_tx_idle_type); // RQ16
            if (serial_mode) begin
                txd[3:2] <= 2'b00;
                txd[1]   <= ctrl[mpi_pkg::ctrl_loop_bit]; // RQ17
                txd[0]   <= tx_byte[ser_bit]; // RQ17
            end else if (tx_state == mpi_tx_pre_type) begin
                txd <= (pre_cnt == mpi_pkg::pre_nibbles) ?
                    mpi_pkg::sfd_high : mpi_pkg::pre_nibble;
            end else if (tx_state == mpi_tx_lo_type) begin
                txd <= tx_byte[3:0]; // RQ15
            end else begin
                txd <= tx_byte[7:4]; // RQ15
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive: nibbles sampled on rx rise, preamble skipped until sfd
    logic       rx_in_frame, rx_half;
    logic [3:0] rx_lo;
    logic [2:0] rx_cnt, da_cnt;
    logic       rx_ready, rx_err_ev, da_match;
    logic [7:0] rx_shift;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_in_frame <= 1'b0;
            rx_half     <= 1'b0;
            rx_lo       <= 4'h0;
            rx_shift    <= 8'h00;
            rx_cnt      <= 3'h0;
            rx_ready    <= 1'b0;
            rx_err_ev   <= 1'b0;
            rx_byte     <= 8'h00;
            rx_byte_err <= 1'b0;
        end else begin
            rx_ready  <= 1'b0;
            rx_err_ev <= 1'b0;
            if (rxc_rise && serial_mode) begin
                // one bit per edge on rx bit 0 while carrier is up
                if (crs_lvl) begin
                    rx_shift <= {rxd_s[0], rx_shift[7:1]}; // RQ13
                    rx_cnt   <= rx_cnt + 3'h1;
                    if (rx_cnt == 3'h7) begin
                        rx_byte  <= {rxd_s[0], rx_shift[7:1]};
                        rx_ready <= 1'b1;
                    end
                end else begin
                    rx_cnt <= 3'h0;
                end
            end else if (rxc_rise) begin // RQ7
                if (!dv_lvl) begin
                    rx_in_frame <= 1'b0;
                    rx_half     <= 1'b0;
                end else if (!rx_in_frame) begin
                    // nibbles before the sfd nibble are preamble
                    if (rxd_s == mpi_pkg::sfd_high && rx_half)
                        rx_in_frame <= 1'b1; // RQ10
                    rx_half <= (rxd_s == mpi_pkg::pre_nibble);
                end else begin
                    if (err_lvl) rx_err_ev <= 1'b1;
                    if (!rx_half) begin
                        rx_lo   <= rxd_s; // RQ8
                        rx_half <= 1'b1;
                    end else begin
                        rx_byte     <= {rxd_s, rx_lo}; // RQ8
                        rx_byte_err <= err_lvl;
                        rx_ready    <= 1'b1;
                        rx_half     <= 1'b0;
                    end
                end
                if (!rx_in_frame) rx_half <= dv_lvl &&
                    rxd_s == mpi_pkg::pre_nibble;
            end
        end
    end

    // rx byte valid flag, cleared by reading the rx data register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) rx_byte_new <= 1'b0;
        else if (rx_ready) rx_byte_new <= 1'b1;
        else if (rd_hit && avs_address == mpi_pkg::rxdata_addr)
            rx_byte_new <= 1'b0;
    end

    // destination address compare against filter low bytes, mod four
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            da_cnt   <= 3'h0;
            da_match <= 1'b1;
            comp_act <= 1'b0;
        end else if (!crs_lvl) begin
            da_cnt   <= 3'h0;
            da_match <= 1'b1;
            comp_act <= 1'b0;
        end else if (rx_ready && da_cnt != mpi_pkg::da_bytes) begin
            da_cnt <= da_cnt + 3'h1;
            if (rx_byte != filter[8*da_cnt[1:0] +: 8]) da_match <= 1'b0;
            if (da_cnt == mpi_pkg::da_bytes - 3'h1) // RQ2
                comp_act <= (da_match && rx_byte ==
                    filter[8*da_cnt[1:0] +: 8]) ^
                    ctrl[mpi_pkg::ctrl_nomatch_bit]; // RQ3
        end
    end

    // events into the sticky status register
    always_comb begin
        ev = '0;
        ev[mpi_pkg::ev_rxbyte] = rx_ready;
        ev[mpi_pkg::ev_rxerr]  = rx_err_ev;
        ev[mpi_pkg::ev_txdone] = tx_done;
        ev[mpi_pkg::ev_col]    = col_rise;
        ev[mpi_pkg::ev_link]   = serial_mode & (link_chg_r | link_chg_f);
    end
endmodule

// file: shared/mpi_pkg.sv
// package: register map, field positions and constants of the mii pin block
package mpi_pkg;
    // register word offsets on the avalon slave
    localparam logic [3:0] ctrl_addr     = 4'h0;
    localparam logic [3:0] status_addr   = 4'h1;
    localparam logic [3:0] irq_addr      = 4'h2;
    localparam logic [3:0] mask_addr     = 4'h3;
    localparam logic [3:0] txdata_addr   = 4'h4;
    localparam logic [3:0] rxdata_addr   = 4'h5;
    localparam logic [3:0] filter_addr   = 4'h6;
    // control register fields
    localparam int ctrl_serial_bit   = 0;
    localparam int ctrl_loop_bit     = 1;
    localparam int ctrl_nomatch_bit  = 2;
    localparam int ctrl_pol_bit      = 3;
    localparam int ctrl_txerr_bit    = 4;
    localparam logic [31:0] ctrl_reset = 32'h0000_0000;
    // tx data register fields
    localparam int txd_last_bit      = 8;
    // rx data register fields
    localparam int rxd_valid_bit     = 8;
    localparam int rxd_err_bit       = 9;
    // status register fields
    localparam int st_link_bit       = 0;
    localparam int st_crs_bit        = 1;
    localparam int st_col_bit        = 2;
    localparam int st_txbusy_bit     = 3;
    localparam int st_txroom_bit     = 4;
    // event bits, shared by irq status and mask
    localparam int ev_rxbyte         = 0;
    localparam int ev_rxerr          = 1;
    localparam int ev_txdone         = 2;
    localparam int ev_col            = 3;
    localparam int ev_link           = 4;
    localparam int ev_width          = 5;
    // frame framing: preamble nibbles before the sfd high nibble
    localparam logic [4:0] pre_nibbles = 5'h0F;
    localparam logic [3:0] pre_nibble  = 4'h5;
    localparam logic [3:0] sfd_high    = 4'hD;
    // destination address length in bytes
    localparam logic [2:0] da_bytes    = 3'h6;
    localparam logic [31:0] filter_reset = 32'h0000_0000;
endpackage

// file: rtl/mpi_edge_sync.sv
// two flip-flop synchroniser with rise and fall detection
`timescale 1ns/10ps
module mpi_edge_sync (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic async_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta;
    logic held;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta  <= 1'b0;
            level <= 1'b0;
            held  <= 1'b0;
        end else begin
            meta  <= async_in;
            level <= meta;
            held  <= level;
        end
    end

    assign rise = level & ~held;
    assign fall = ~level & held;
endmodule

// file: bench/mpi_monitor.sv
// checker: bus, framing and interrupt relations at the mii block ports
`timescale 1ns/10ps
module mpi_monitor (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic       irq,
    input wire logic       tx_clk,
    input wire logic [3:0] txd,
    input wire logic       tx_en
);
    logic       txc_q;
    logic [2:0] pos;
    logic [4:0] nib;
    // cycles since the raw tx clock rose; pin values are judged at pos 7, pin changes at pos 1 to 5
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txc_q <= 1'b0;
            pos   <= 3'h7;
        end else begin
            txc_q <= tx_clk;
            if (tx_clk && !txc_q) pos <= 3'h0;
            else if (pos != 3'h7) pos <= pos + 3'h1;
        end
    end
    // settled nibbles of the frame, saturating so long frames cannot wrap
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) nib <= 5'h00;
        else if (pos == 3'h7 && !tx_en) nib <= 5'h00;
        else if (pos == 3'h7 && nib != 5'h1F) nib <= nib + 5'h01;
    end
    chk_bus_ready: assert property (@(posedge clk) disable iff (!nrst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low twice in a row");
    chk_tx_phase: assert property (@(posedge clk) disable iff (!nrst)
        (tx_en && $changed(txd)) || $changed(tx_en) |-> pos inside {[1:5]})
        else $error("tx pins moved away from tx clock rise");
    chk_pre_nibble: assert property (@(posedge clk) disable iff (!nrst)
        pos == 3'h7 && tx_en && nib < mpi_pkg::pre_nibbles
        |-> txd == mpi_pkg::pre_nibble)
        else $error("bad preamble nibble");
    chk_sfd_nibble: assert property (@(posedge clk) disable iff (!nrst)
        pos == 3'h7 && tx_en && nib == mpi_pkg::pre_nibbles
        |-> txd == mpi_pkg::sfd_high)
        else $error("bad delimiter nibble");
    chk_tx_even: assert property (@(posedge clk) disable iff (!nrst)
        $fell(tx_en) |-> !nib[0])
        else $error("frame ended on half a byte");
    chk_tx_min: assert property (@(posedge clk) disable iff (!nrst)
        $fell(tx_en) |-> nib >= mpi_pkg::pre_nibbles + 5'h03)
        else $error("frame shorter than preamble and one byte");
    chk_en_hold: assert property (@(posedge clk) disable iff (!nrst)
        $rose(tx_en) |-> tx_en [*8])
        else $error("tx enable shorter than one nibble");
    chk_irq_fall: assert property (@(posedge clk) disable iff (!nrst)
        $fell(irq) |-> $past(avs_write) || $past(avs_write, 2)
        || $past(avs_write, 3))
        else $error("interrupt dropped without a bus write");
endmodule
bind mpi_core mpi_monitor mpi_monitor_i (.clk(clk), .nrst(nrst),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .tx_clk(tx_clk), .txd(txd), .tx_en(tx_en));

// file: bench/mpi_phy_model.sv
// far-side transceiver model: free clocks, receive frames, tx capture
`timescale 1ns/10ps
module mpi_phy_model (
    output logic            rx_clk,
    output logic            tx_clk,
    output logic [3:0]      rxd,
    output logic            rx_dv,
    output logic            rx_err,
    output logic            crs,
    output logic            col,
    input  wire logic [3:0] txd,
    input  wire logic       tx_en
);
    logic [4:0] q[$];
    logic [7:0] got[$];
    logic [3:0] lo;
    logic       link;
    logic       carr;
    logic       coll;
    int         n;
    // clocks run free at the nibble rate, phases unrelated to the core
    initial begin
        rx_clk = 1'b0;
        forever #160 rx_clk = ~rx_clk;
    end
    initial begin
        tx_clk = 1'b0;
        #77;
        forever #160 tx_clk = ~tx_clk;
    end
    initial begin
        {rxd, rx_dv, rx_err, crs, col, link, carr, coll} = 10'h000;
        n = 0;
    end
    // drive on falling edge; idle lines toggle so stale data cannot match
    always @(negedge rx_clk) begin
        rx_dv <= (q.size() != 0) | link;
        crs <= (q.size() != 0) | carr;
        if (q.size() != 0) {rx_err, rxd} <= q.pop_front();
        else {rx_err, rxd} <= {1'b0, ~rxd};
        col <= coll;
    end
    // preamble and delimiter first, then low nibble of each byte
    task automatic send(input logic [7:0] b[$], input logic err_last);
        for (int i = 0; i < 15; i++) q.push_back(5'h05);
        q.push_back(5'h0D);
        foreach (b[i]) begin
            q.push_back({err_last && i == b.size() - 1, b[i][3:0]});
            q.push_back({err_last && i == b.size() - 1, b[i][7:4]});
        end
    endtask
    // capture on rising tx clock, skipping the sixteen framing nibbles
    always @(posedge tx_clk) begin
        if (!tx_en) n = 0;
        else begin
            if (n >= 16 && !n[0]) lo = txd;
            else if (n >= 16) got.push_back({txd, lo});
            n++;
        end
    end
endmodule

// file: bench/testbench.sv
// testbench: bus tasks, frame traffic and checks for the mii pin block
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
    logic        clk, nrst, avs_read, avs_write, avs_waitrequest, irq;
    logic [3:0]  avs_address, txd, rxd;
    logic [31:0] avs_writedata, avs_readdata, d, seed;
    logic        tx_clk, tx_en, tx_err, rx_clk, rx_dv, rx_err, crs, col;
    logic [7:0]  exp[$];
    int          miscompares, checks, n;
    mpi_core mpi_core_i (.clk(clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .tx_clk(tx_clk),
        .txd(txd), .tx_en(tx_en), .tx_err(tx_err), .rx_clk(rx_clk),
        .rxd(rxd), .rx_dv(rx_dv), .rx_err(rx_err), .crs(crs), .col(col));
    mpi_phy_model mpi_phy_model_i (.rx_clk(rx_clk), .tx_clk(tx_clk),
        .rxd(rxd), .rx_dv(rx_dv), .rx_err(rx_err), .crs(crs), .col(col),
        .txd(txd), .tx_en(tx_en));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic exp_irq(input logic [31:0] st, m);
        return |(st[4:0] & m[4:0]);
    endfunction
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    // read data are taken at the edge that finds waitrequest low
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask
    task automatic poll(input logic [3:0] a, input int b, input logic v);
        n = 0;
        do begin rd(a); n++; end while (d[b] !== v && n < 100);
    endtask
    task automatic wait_lvl(input int w, input logic v);
        n = 0;
        while (((w == 0) ? irq : txd[1]) !== v && n < 40) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // hang guard, far beyond the several hundred cycles the tests need
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        end_sim();
    end
    initial begin
        {nrst, avs_read, avs_write, avs_address, avs_writedata} = 39'h0;
        {miscompares, checks, seed} = {32'h0, 32'h0, 32'hEEBDFAF3};
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        rd(mpi_pkg::ctrl_addr);
        `CHK(d, mpi_pkg::ctrl_reset)
        rd(mpi_pkg::filter_addr);
        `CHK(d, mpi_pkg::filter_reset)
        wr(4'hF, 32'hFFFFFFFF);
        rd(4'hF);
        `CHK(d, 32'h0)
        $display("test reset done");
        // one-byte and three-byte frames with random payload
        for (int k = 0; k < 2; k++) begin
            mpi_phy_model_i.got.delete();
            exp.delete();
            for (int i = 0; i < 2 * k + 1; i++) begin
                seed = lfsr(seed);
                exp.push_back(seed[7:0]);
                poll(mpi_pkg::status_addr, mpi_pkg::st_txroom_bit, 1'b1);
                wr(mpi_pkg::txdata_addr, {23'h0, i == 2 * k, seed[7:0]});
            end
            n = 0;
            while (mpi_phy_model_i.got.size() < exp.size() && n < 3000) begin
                @(posedge clk);
                n++;
            end
            foreach (exp[i]) `CHK(mpi_phy_model_i.got[i], exp[i])
        end
        $display("test transmit done");
        // done event is sticky, masked first, then unmasked and cleared
        rd(mpi_pkg::irq_addr);
        `CHK(d[mpi_pkg::ev_txdone], 1'b1)
        `CHK(irq, exp_irq(d, 32'h0))
        wr(mpi_pkg::mask_addr, 32'h1 << mpi_pkg::ev_txdone);
        wait_lvl(0, 1'b1);
        `CHK(irq, exp_irq(d, 32'h1 << mpi_pkg::ev_txdone))
        wr(mpi_pkg::irq_addr, 32'h1 << mpi_pkg::ev_txdone);
        wait_lvl(0, 1'b0);
        `CHK(irq, 1'b0)
        rd(mpi_pkg::irq_addr);
        `CHK(d[mpi_pkg::ev_txdone], 1'b0)
        $display("test interrupt done");
        // three random bytes received, the last one flagged in error
        exp.delete();
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            exp.push_back(seed[7:0]);
        end
        mpi_phy_model_i.send(exp, 1'b1);
        foreach (exp[i]) begin
            poll(mpi_pkg::rxdata_addr, mpi_pkg::rxd_valid_bit, 1'b1);
            `CHK(d[7:0], exp[i])
            `CHK(d[mpi_pkg::rxd_err_bit], i == 2)
        end
        rd(mpi_pkg::irq_addr);
        `CHK(d[mpi_pkg::ev_rxerr], 1'b1)
        $display("test receive done");
        // carrier and collision reach status through the synchroniser
        for (int v = 1; v >= 0; v--) begin
            {mpi_phy_model_i.carr, mpi_phy_model_i.coll} = {2{v[0]}};
            poll(mpi_pkg::status_addr, mpi_pkg::st_col_bit, v[0]);
            `CHK(d[mpi_pkg::st_col_bit], v[0])
            poll(mpi_pkg::status_addr, mpi_pkg::st_crs_bit, v[0]);
            `CHK(d[mpi_pkg::st_crs_bit], v[0])
        end
        $display("test carrier done");
        // serial mode: loopback on tx bit 1, data valid read as link
        for (int v = 1; v >= 0; v--) begin
            wr(mpi_pkg::ctrl_addr, {28'h0, v[0], 1'b0, v[0], 1'b1});
            wait_lvl(1, v[0]);
            `CHK(txd[1], v[0])
            `CHK(tx_err, !v[0])
            mpi_phy_model_i.link = v[0];
            poll(mpi_pkg::status_addr, mpi_pkg::st_link_bit, v[0]);
            `CHK(d[mpi_pkg::st_link_bit], v[0])
        end
        wr(mpi_pkg::ctrl_addr, mpi_pkg::ctrl_reset);
        $display("test serial done");
        end_sim();
    end
endmodule
